// *** rtl/ien_pkg.sv ***
// package for the interrupt enable and masking block
// assumes one core clock and a word-wide register port
package ien_pkg;
   localparam int unsigned NUM_LINES = 32;
   localparam int unsigned ID_W = 5;
   localparam int unsigned PRIO_W = 2;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;
   localparam logic [ADDR_W-1:0] OFS_ENABLE_SET = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_ENABLE_CLEAR = 12'h080;
   localparam logic [DATA_W-1:0] ENABLE_RESET = 32'h00000000;
   localparam logic [DATA_W-1:0] READ_UNMAPPED = 32'h00000000;

   typedef struct packed {
      logic valid;
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } ien_req_t;

   typedef struct packed {
      logic valid;
      logic [DATA_W-1:0] rdata;
   } ien_rsp_t;
endpackage

// *** rtl/ien_arb.sv ***
// priority pick among candidate interrupt lines
// assumes lower priority value is more urgent, ties go to lower index
`timescale 1ns/1ps
module ien_arb (
   input wire logic [ien_pkg::NUM_LINES-1:0] cand_in, // eligible lines
   input wire logic [ien_pkg::NUM_LINES*ien_pkg::PRIO_W-1:0] prio_in, // prios
   output logic found_out, // any candidate
   output logic [ien_pkg::ID_W-1:0] id_out // winning line
);
   logic [ien_pkg::PRIO_W-1:0] best;
   logic [ien_pkg::PRIO_W-1:0] cur;

   always_comb begin
      found_out = 1'b0;
      id_out = '0;
      best = '1;
      cur = '0;
      // descending scan so ties settle on the lowest index
      for (int i = ien_pkg::NUM_LINES - 1; i >= 0; i--) begin
         cur = prio_in[i*ien_pkg::PRIO_W +: ien_pkg::PRIO_W];
         if (cand_in[i] && (!found_out || cur <= best)) begin
            found_out = 1'b1;
            best = cur;
            id_out = ien_pkg::ID_W'(i);
         end
      end
   end
endmodule

// *** rtl/ien_core.sv ***
// interrupt enable, pending and global mask logic of the controller
// assumes aligned word accesses on the register port and a core that
// acknowledges the presented interrupt with a one-cycle pulse
`timescale 1ns/1ps
module ien_core (
   input wire logic CLK_IN, // core clock, 200 MHz
   input wire logic RSTN_IN, // synchronous reset, active low
   input wire ien_pkg::ien_req_t REG_REQ_IN, // register access
   output ien_pkg::ien_rsp_t REG_RSP_OUT, // read answer, next cycle
   input wire logic [ien_pkg::NUM_LINES-1:0] IRQ_LINES_IN, // requests
   input wire logic [ien_pkg::NUM_LINES*ien_pkg::PRIO_W-1:0] PRIO_IN, // prio
   input wire logic MASK_SET_IN, // mask instruction executed
   input wire logic MASK_CLR_IN, // unmask instruction executed
   input wire logic NMI_IN, // non-maskable request
   input wire logic ACK_IN, // core takes presented interrupt
   input wire logic NMI_ACK_IN, // core takes non-maskable interrupt
   output logic TAKE_OUT, // interrupt presented to core
   output logic [ien_pkg::ID_W-1:0] TAKE_ID_OUT, // presented line
   output logic NMI_TAKE_OUT, // non-maskable presented
   output logic MASK_OUT, // global mask state
   output logic [ien_pkg::NUM_LINES-1:0] PENDING_OUT // pending lines
);
   logic [ien_pkg::NUM_LINES-1:0] enable;
   logic [ien_pkg::NUM_LINES-1:0] pending;
   logic gmask;
   logic nmi_pend;
   logic take;
   logic [ien_pkg::ID_W-1:0] take_id;
   ien_pkg::ien_rsp_t rsp;

   wire wr_set = REG_REQ_IN.valid && REG_REQ_IN.write &&
      REG_REQ_IN.addr == ien_pkg::OFS_ENABLE_SET;
   wire wr_clr = REG_REQ_IN.valid && REG_REQ_IN.write &&
      REG_REQ_IN.addr == ien_pkg::OFS_ENABLE_CLEAR;
   wire rd = REG_REQ_IN.valid && !REG_REQ_IN.write;
   wire rd_hit = REG_REQ_IN.addr == ien_pkg::OFS_ENABLE_SET ||
      REG_REQ_IN.addr == ien_pkg::OFS_ENABLE_CLEAR;

   // one vector behind both registers
   wire [ien_pkg::NUM_LINES-1:0] set_bits =
      wr_set ? REG_REQ_IN.wdata : '0;
   wire [ien_pkg::NUM_LINES-1:0] clr_bits =
      wr_clr ? REG_REQ_IN.wdata : '0;
   wire [ien_pkg::NUM_LINES-1:0] next_enable =
      (enable | set_bits) & ~clr_bits;

   // ack clears only the presented line; a new request wins the clear
   wire [ien_pkg::NUM_LINES-1:0] ack_bits =
      (ACK_IN && take) ? (ien_pkg::NUM_LINES'(1) << take_id) : '0;
   wire [ien_pkg::NUM_LINES-1:0] next_pending =
      (pending & ~ack_bits) | IRQ_LINES_IN;

   // only enabled, pending, unmasked lines compete
   wire [ien_pkg::NUM_LINES-1:0] cand =
      gmask ? '0 : (pending & enable);
   logic arb_found;
   logic [ien_pkg::ID_W-1:0] arb_id;

   ien_arb u_arb (
      .cand_in(cand),
      .prio_in(PRIO_IN),
      .found_out(arb_found),
      .id_out(arb_id)
   );

   // mask instruction wins if both arrive together (safer side)
   wire next_gmask = MASK_SET_IN ? 1'b1 :
      (MASK_CLR_IN ? 1'b0 : gmask);
   // independent of gmask on purpose
   wire next_nmi = NMI_IN || (nmi_pend && !NMI_ACK_IN);

   // reads of either offset return the enable vector
   // between reads the last answer stands, so it can be taken late
   wire [ien_pkg::DATA_W-1:0] next_rdata = !rd ? rsp.rdata :
      (rd_hit ? enable : ien_pkg::READ_UNMAPPED);

   always_ff @(posedge CLK_IN) begin
      if (!RSTN_IN) begin
         enable <= ien_pkg::ENABLE_RESET;
         pending <= '0;
         gmask <= 1'b0;
         nmi_pend <= 1'b0;
         take <= 1'b0;
         take_id <= '0;
         rsp <= '0;
      end else begin
         enable <= next_enable;
         pending <= next_pending;
         gmask <= next_gmask;
         nmi_pend <= next_nmi;
         take <= arb_found;
         take_id <= arb_id;
         rsp.valid <= rd;
         rsp.rdata <= next_rdata;
      end
   end

   assign REG_RSP_OUT = rsp;
   assign TAKE_OUT = take;
   assign TAKE_ID_OUT = take_id;
   assign NMI_TAKE_OUT = nmi_pend;
   assign MASK_OUT = gmask;
   assign PENDING_OUT = pending;

   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RSTN_IN);

   sequence s_read_enable;
      rd && rd_hit;
   endsequence

   sequence s_ack_taken;
      ACK_IN && take;
   endsequence

   sequence s_line_ready;
      (pending & enable) != '0 && !gmask;
   endsequence

   // any candidate that should have beaten the pick, for the checks
   logic outranked;
   logic [ien_pkg::PRIO_W-1:0] prio_i;
   wire [ien_pkg::PRIO_W-1:0] prio_win =
      PRIO_IN[arb_id*ien_pkg::PRIO_W +: ien_pkg::PRIO_W];

   always_comb begin
      outranked = 1'b0;
      prio_i = '0;
      for (int i = 0; i < ien_pkg::NUM_LINES; i++) begin
         prio_i = PRIO_IN[i*ien_pkg::PRIO_W +: ien_pkg::PRIO_W];
         if (cand[i] && (prio_i < prio_win ||
               (prio_i == prio_win && ien_pkg::ID_W'(i) < arb_id))) begin
            outranked = 1'b1;
         end
      end
   end

   a_set_enable_bits: assert property (
      wr_set && !wr_clr |=> (enable & $past(REG_REQ_IN.wdata))
         == $past(REG_REQ_IN.wdata))
      else $error("set-enable write did not enable lines");

   a_set_zero_keeps: assert property (
      wr_set |=> (enable & ~$past(REG_REQ_IN.wdata))
         == ($past(enable) & ~$past(REG_REQ_IN.wdata)))
      else $error("set-enable zero bits changed state");

   a_clear_enable_bits: assert property (
      wr_clr |=> (enable & $past(REG_REQ_IN.wdata)) == '0)
      else $error("clear-enable write left lines enabled");

   // zero bits of a clear write must leave their lines alone
   a_clear_zero_keeps: assert property (
      wr_clr |=> (enable & ~$past(REG_REQ_IN.wdata))
         == ($past(enable) & ~$past(REG_REQ_IN.wdata)))
      else $error("clear-enable zero bits changed state");

   a_read_shows_enable: assert property (
      s_read_enable |=> rsp.valid && rsp.rdata == $past(enable))
      else $error("enable read returned wrong value");

   // a late reader must still find its answer unchanged
   a_rdata_holds: assert property (
      !rd |=> $stable(rsp.rdata))
      else $error("read data changed without a read");

   // reset checks opt out of the default disable, or they never run
   a_reset_all_disabled: assert property (
      @(posedge CLK_IN) disable iff (1'b0) !RSTN_IN |=> enable == '0)
      else $error("lines enabled after reset");

   a_reset_clears_state: assert property (
      @(posedge CLK_IN) disable iff (1'b0) !RSTN_IN |=>
         !gmask && pending == '0 && !take && !nmi_pend && !rsp.valid)
      else $error("state not cleared by reset");

   a_disabled_never_taken: assert property (
      take |-> $past(enable[arb_id]) && !$past(gmask))
      else $error("disabled or masked line presented");

   a_disabled_goes_pending: assert property (
      IRQ_LINES_IN != '0 |=> (pending & $past(IRQ_LINES_IN))
         == $past(IRQ_LINES_IN))
      else $error("request did not go pending");

   a_candidate_taken: assert property (
      s_line_ready |=> take)
      else $error("enabled pending line not presented");

   a_ack_clears_line: assert property (
      s_ack_taken |=> !pending[$past(take_id)] ||
         $past(IRQ_LINES_IN[take_id]))
      else $error("acknowledged line still pending");

   a_mask_set_blocks: assert property (
      MASK_SET_IN |=> gmask ##1 !take)
      else $error("mask instruction did not hold interrupts off");

   a_masked_no_take: assert property (
      gmask |=> !take)
      else $error("line presented while masked");

   a_unmask_clears: assert property (
      MASK_CLR_IN && !MASK_SET_IN |=> !gmask)
      else $error("unmask instruction left mask set");

   a_nmi_not_masked: assert property (
      NMI_IN && gmask |=> NMI_TAKE_OUT)
      else $error("mask blocked non-maskable interrupt");

   a_nmi_held_pending: assert property (
      nmi_pend && !NMI_ACK_IN |=> NMI_TAKE_OUT)
      else $error("non-maskable request dropped without ack");

   a_found_any_candidate: assert property (
      arb_found == (cand != '0))
      else $error("pick does not match candidate set");

   a_pick_by_priority: assert property (
      arb_found |-> cand[arb_id] && !outranked)
      else $error("winner outranked by another candidate");
endmodule

// *** tb/ien_core_model.sv ***
// core-side model that takes presented interrupts
// assumes the controller's one-cycle pulse acknowledge contract
`timescale 1ns/1ps
module ien_core_model (
   input wire logic CLK_IN, // core clock
   input wire logic en_in, // accept interrupts when high
   input wire logic take_in, // line presented
   input wire logic nmi_take_in, // non-maskable presented
   output logic ack_out, // take pulse
   output logic nmi_ack_out // non-maskable take pulse
);
   initial begin
      ack_out = 1'b0;
      nmi_ack_out = 1'b0;
   end
   // every other cycle, so a stale presentation is not taken twice
   always @(posedge CLK_IN) begin
      #1;
      ack_out <= en_in & take_in & ~ack_out;
      nmi_ack_out <= en_in & nmi_take_in & ~nmi_ack_out;
   end
endmodule

// *** tb/tb_top.sv ***
// self-checking bench for the enable, pending and mask block
// assumes read answers one cycle after the request
`timescale 1ns/1ps
`define CHK(n,e,s) begin check_count++; if ((s) !== (e)) begin errors++; \
   $display("ERROR %s exp %0h seen %0h", n, e, s); end end
module tb_top;
   logic CLK_IN = 0, RSTN_IN = 0, MASK_SET_IN = 0, MASK_CLR_IN = 0;
   logic NMI_IN = 0, ack_en = 0, ack, nmi_ack, take, nmi_take, mask;
   logic [4:0] id;
   logic [31:0] irq = '0, pend, r, exp_rd, seed = 32'hB9DE, q[$];
   logic [63:0] prio = '0;
   ien_pkg::ien_req_t req = '0;
   ien_pkg::ien_rsp_t rsp;
   int errors = 0, check_count = 0;
   always #2.5 CLK_IN = ~CLK_IN;
   ien_core u_dut (.CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .REG_REQ_IN(req),
      .REG_RSP_OUT(rsp), .IRQ_LINES_IN(irq), .PRIO_IN(prio),
      .MASK_SET_IN(MASK_SET_IN), .MASK_CLR_IN(MASK_CLR_IN), .NMI_IN(NMI_IN),
      .ACK_IN(ack), .NMI_ACK_IN(nmi_ack), .TAKE_OUT(take),
      .TAKE_ID_OUT(id), .NMI_TAKE_OUT(nmi_take), .MASK_OUT(mask),
      .PENDING_OUT(pend));
   ien_core_model u_core (.CLK_IN(CLK_IN), .en_in(ack_en), .take_in(take),
      .nmi_take_in(nmi_take), .ack_out(ack), .nmi_ack_out(nmi_ack));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(posedge CLK_IN);
      #1;
   endtask
   // whole aligned words only
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      req = '{1'b1, 1'b1, a, d};
      cyc(1);
      req = '0;
      cyc(1);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      q.push_back(e);
      req = '{1'b1, 1'b0, a, 32'h0};
      cyc(1);
      req = '0;
      cyc(1);
   endtask
   always @(posedge CLK_IN) if (rsp.valid === 1'b1) begin
      exp_rd = q.pop_front();
      `CHK("rdata", exp_rd, rsp.rdata)
   end
   task conclude;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #5000;
      errors++;
      conclude();
   end
   initial begin
      cyc(2);
      RSTN_IN = 1;
      rd(12'h000, 32'h0);
      rd(12'h080, 32'h0);
      r = xs();
      wr(12'h000, r);
      rd(12'h080, r);
      wr(12'h000, 32'h00000088);
      rd(12'h000, r | 32'h00000088);
      wr(12'h080, 32'hFFFFFF77);
      wr(12'h080, 32'h0);
      rd(12'h000, 32'h00000088);
      rd(12'h040, 32'h0);
      prio = {xs(), xs()};
      irq = 32'h000000A8;
      cyc(1);
      irq = '0;
      cyc(2);
      `CHK("pending", 32'h000000A8, pend)
      `CHK("take", 1'b1, take)
      `CHK("id", (prio[15:14] < prio[7:6]) ? 5'h07 : 5'h03, id)
      MASK_SET_IN = 1;
      cyc(1);
      MASK_SET_IN = 0;
      NMI_IN = 1;
      cyc(1);
      NMI_IN = 0;
      cyc(1);
      `CHK("mask", 1'b1, mask)
      `CHK("take", 1'b0, take)
      `CHK("nmi", 1'b1, nmi_take)
      MASK_CLR_IN = 1;
      cyc(1);
      MASK_CLR_IN = 0;
      cyc(2);
      `CHK("mask", 1'b0, mask)
      `CHK("take", 1'b1, take)
      ack_en = 1;
      cyc(10);
      `CHK("pending", 32'h00000020, pend)
      `CHK("take", 1'b0, take)
      `CHK("nmi", 1'b0, nmi_take)
      wr(12'h000, 32'h00000020);
      `CHK("take", 1'b1, take)
      `CHK("id", 5'h05, id)
      cyc(3);
      `CHK("pending", 32'h0, pend)
      RSTN_IN = 0;
      cyc(2);
      RSTN_IN = 1;
      rd(12'h080, 32'h0);
      MASK_SET_IN = 1;
      MASK_CLR_IN = 1;
      cyc(1);
      MASK_SET_IN = 0;
      MASK_CLR_IN = 0;
      `CHK("mask", 1'b1, mask)
      `CHK("reads left", 0, q.size())
      conclude();
   end
endmodule
